// >>> hw/wrs_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "wrs_consts.svh"

module wrs_device #(
  parameter int unsigned SHORT_RST_CYC = `WRS_SHORT_RST_US * `WRS_CLK_MHZ,
  parameter int unsigned LONG_RST_CYC = `WRS_LONG_RST_US * `WRS_CLK_MHZ,
  parameter int unsigned STARTUP_CYC = `WRS_STARTUP_US * `WRS_CLK_MHZ,
  parameter int unsigned CLAMP_LOW_CYC = `WRS_CLAMP_LOW_US * `WRS_CLK_MHZ,
  parameter int unsigned CLAMP_HIGH_CYC = `WRS_CLAMP_HIGH_US * `WRS_CLK_MHZ,
  parameter int unsigned WD_UNIT_CYC = `WRS_WD_UNIT_US * `WRS_CLK_MHZ
) (
  input wire logic clock_i, // System clock.
  input wire logic srst_i, // Synchronous reset, acts as power-on.
  wrs_link_if.dev link, // Service strobes, reset wire and status.
  input wire logic [2:0] v1_below_i, // Supply below each of three thresholds.
  input wire logic [1:0] uv_sel_i, // Chosen undervoltage threshold.
  input wire logic cur_low_i, // Supply current below low threshold.
  input wire logic cur_high_i, // Supply current above high threshold.
  input wire logic wake_i, // Wake-up event level.
  input wire logic irq_late_i, // Interrupt left unread past deadline.
  input wire logic wdr_irq_en_i, // Watchdog restart interrupt enable.
  output var wrs_pkg::wrs_state_t state_o, // Supervisor state.
  output logic v1_en_o, // Supply regulator enable.
  output logic rlc_o, // Long reset selected.
  output logic wdr_irq_o // Watchdog restart interrupt pulse.
);
  import wrs_pkg::*;

  localparam logic [23:0] SHORT_C = 24'(SHORT_RST_CYC);
  localparam logic [23:0] LONG_C = 24'(LONG_RST_CYC);
  localparam logic [23:0] STARTUP_C = 24'(STARTUP_CYC);
  localparam logic [23:0] CLT_C = 24'(CLAMP_LOW_CYC);
  localparam logic [23:0] CHT_C = 24'(CLAMP_HIGH_CYC);
  localparam logic [23:0] UNIT_C = 24'(WD_UNIT_CYC);

  wrs_state_t state_reg, go;
  logic pin_s1, pin_s2, pin_q;
  logic [6:0] in_s1, in_s2;
  logic drive_reg, rlc_reg, en_reg, v1_en_reg, wdr_irq_reg, flash_armed_reg;
  logic wd_run_reg, off_sel_reg, cur_low_seen_reg;
  logic [3:0] src_reg, ev_src;
  logic [23:0] rst_cnt_reg, wd_cnt_reg, per_reg, clamp_cnt_reg;
  logic ev_rst, ev_fs, svc_ok, set_rlc, max_per, wd_stop, wd_wake;
  logic quiet, is_start, uv_now, ext_fall, lo_run, hi_run, clamp_hit;
  logic per_ok, off_code, wd_over, early, svc;

  // Pin and analogue inputs pass two flip-flops before use.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_q <= 1'b1;
      in_s1 <= 7'h00;
      in_s2 <= 7'h00;
    end else begin
      pin_s1 <= link.rst_level;
      pin_s2 <= pin_s1;
      pin_q <= pin_s2;
      in_s1 <= {v1_below_i, cur_low_i, cur_high_i, wake_i, irq_late_i};
      in_s2 <= in_s1;
    end
  end

  // Decoded conditions used by the event logic.
  assign svc = link.svc_valid;
  assign quiet = (state_reg == ST_SLEEP) || (state_reg == ST_FAILSAFE);
  assign is_start = (state_reg == ST_STARTUP) || (state_reg == ST_RESTART);
  assign uv_now = in_s2[4 + ((uv_sel_i == 2'h3) ? 2 : int'(uv_sel_i))];
  assign ext_fall = pin_q && !pin_s2 && !drive_reg && !quiet;
  assign lo_run = !drive_reg && !pin_s2 && !quiet;
  assign hi_run = drive_reg && pin_s2;
  assign clamp_hit = (lo_run && clamp_cnt_reg >= CLT_C) || (hi_run && clamp_cnt_reg >= CHT_C);
  assign per_ok = link.svc_period < `WRS_PERIOD_CODES;
  assign off_code = link.svc_period == `WRS_PERIOD_OFF;
  assign wd_over = wd_run_reg && !is_start && (wd_cnt_reg >= per_reg);
  assign early = wd_cnt_reg < {1'b0, per_reg[23:1]};

  // Event arbitration and next state.
  always_comb begin
    ev_rst = 1'b0;
    ev_fs = 1'b0;
    ev_src = src_reg;
    go = state_reg;
    svc_ok = 1'b0;
    set_rlc = 1'b0;
    max_per = 1'b0;
    wd_stop = 1'b0;
    wd_wake = 1'b0;
    if (clamp_hit) begin
      ev_fs = 1'b1;
    end else if (uv_now && !quiet) begin
      ev_rst = 1'b1;
      ev_src = `WRS_SRC_UV;
    end else if (ext_fall) begin
      ev_rst = 1'b1;
      ev_src = `WRS_SRC_EXT;
    end else if (in_s2[0] && !quiet) begin
      ev_rst = 1'b1;
      ev_src = `WRS_SRC_IRQ;
    end else begin
      case (state_reg)
        ST_STARTUP, ST_RESTART: begin
          if (!drive_reg && svc) begin
            if (link.svc_mode == `WRS_MODE_NORMAL && per_ok) begin
              go = ST_NORMAL;
              svc_ok = 1'b1;
            end else if (link.svc_mode == `WRS_MODE_FLASH_ENTER && flash_armed_reg && per_ok) begin
              go = ST_FLASH;
              svc_ok = 1'b1;
            end else if (wrs_mode_ok(link.svc_mode) && !per_ok) begin
              ev_rst = 1'b1;
              ev_src = `WRS_SRC_WD;
            end else begin
              ev_rst = 1'b1;
              ev_src = `WRS_SRC_ILL_MODE;
            end
          end else if (!drive_reg && wd_cnt_reg >= STARTUP_C) begin
            if (state_reg == ST_RESTART) begin
              ev_fs = 1'b1;
            end else begin
              ev_rst = 1'b1;
              ev_src = `WRS_SRC_STARTUP;
              go = ST_RESTART;
              set_rlc = 1'b1;
            end
          end
        end
        ST_NORMAL: begin
          if (svc) begin
            ev_rst = 1'b1;
            ev_src = `WRS_SRC_WD;
            if (!wrs_mode_ok(link.svc_mode)) begin
              ev_src = `WRS_SRC_ILL_MODE;
            end else if (early || !(per_ok || (off_code && link.svc_mode != `WRS_MODE_NORMAL))) begin
              ev_src = `WRS_SRC_WD;
            end else if (link.svc_mode == `WRS_MODE_NORMAL) begin
              ev_rst = 1'b0;
              svc_ok = 1'b1;
            end else if (link.svc_mode == `WRS_MODE_STANDBY) begin
              ev_rst = 1'b0;
              svc_ok = 1'b1;
              go = ST_STANDBY;
              max_per = 1'b1;
            end else if (link.svc_mode == `WRS_MODE_SLEEP) begin
              ev_rst = 1'b0;
              svc_ok = 1'b1;
              go = ST_SLEEP;
            end else if (link.svc_mode == `WRS_MODE_FLASH_SVC) begin
              ev_src = `WRS_SRC_FLASH_PREP;
            end else begin
              ev_src = `WRS_SRC_ILL_MODE;
            end
          end else if (wd_over) begin
            ev_rst = 1'b1;
            ev_src = `WRS_SRC_WD;
          end
        end
        ST_STANDBY, ST_SLEEP: begin
          if (svc && state_reg == ST_STANDBY) begin
            ev_rst = 1'b1;
            ev_src = `WRS_SRC_ILL_MODE;
            if (!wrs_mode_ok(link.svc_mode)) begin
              ev_src = `WRS_SRC_ILL_MODE;
            end else if (!(per_ok || (off_code && link.svc_mode != `WRS_MODE_NORMAL))) begin
              ev_src = `WRS_SRC_WD;
            end else if (link.svc_mode == `WRS_MODE_NORMAL) begin
              ev_rst = 1'b0;
              svc_ok = 1'b1;
              go = ST_NORMAL;
            end else if (link.svc_mode == `WRS_MODE_STANDBY) begin
              ev_rst = 1'b0;
              svc_ok = 1'b1;
            end else if (link.svc_mode == `WRS_MODE_SLEEP) begin
              ev_rst = 1'b0;
              svc_ok = 1'b1;
              go = ST_SLEEP;
            end
          end else if (wd_over) begin
            if (off_sel_reg && (state_reg == ST_SLEEP || cur_low_seen_reg)) begin
              wd_stop = 1'b1;
            end else begin
              ev_rst = 1'b1;
              ev_src = `WRS_SRC_WD;
            end
          end else if (in_s2[1]) begin
            ev_rst = 1'b1;
            ev_src = `WRS_SRC_WAKE;
          end else if (state_reg == ST_STANDBY && !wd_run_reg && in_s2[2]) begin
            wd_wake = 1'b1;
            ev_rst = !wdr_irq_en_i;
            ev_src = `WRS_SRC_CURRENT;
          end
        end
        ST_FLASH: begin
          if (svc) begin
            ev_rst = 1'b1;
            ev_src = `WRS_SRC_ILL_MODE;
            if (link.svc_mode == `WRS_MODE_FLASH_EXIT) begin
              ev_src = `WRS_SRC_FLASH_EXIT;
            end else if (link.svc_mode == `WRS_MODE_FLASH_SVC && !per_ok) begin
              ev_src = `WRS_SRC_WD;
            end else if (link.svc_mode == `WRS_MODE_FLASH_SVC) begin
              ev_rst = 1'b0;
              svc_ok = 1'b1;
            end
          end else if (wd_over) begin
            ev_rst = 1'b1;
            ev_src = `WRS_SRC_WD;
          end
        end
        ST_FAILSAFE: begin
          if (in_s2[1]) begin
            ev_rst = 1'b1;
            ev_src = `WRS_SRC_FS_WAKE;
          end
        end
        default: begin
          ev_fs = 1'b1;
        end
      endcase
    end
    if (ev_fs) begin
      go = ST_FAILSAFE;
    end else if (ev_rst && go != ST_RESTART) begin
      go = ST_STARTUP;
    end
  end

  // State, reset source and flash-entry arming.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= ST_STARTUP;
      src_reg <= `WRS_SRC_POR;
      flash_armed_reg <= 1'b0;
    end else begin
      state_reg <= go;
      if (ev_rst) begin
        src_reg <= ev_src;
      end
      if (ev_rst || svc_ok) begin
        flash_armed_reg <= ev_rst && ev_src == `WRS_SRC_FLASH_PREP;
      end
    end
  end

  // Reset pin stretching; Sleep and Fail-safe hold the pin low.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      drive_reg <= 1'b1;
      rst_cnt_reg <= SHORT_C;
    end else if (ev_rst) begin
      drive_reg <= 1'b1;
      rst_cnt_reg <= (rlc_reg || set_rlc) ? LONG_C : SHORT_C;
    end else if (go == ST_SLEEP || go == ST_FAILSAFE) begin
      drive_reg <= 1'b1;
    end else if (rst_cnt_reg != 24'h000000) begin
      rst_cnt_reg <= rst_cnt_reg - 24'h000001;
    end else begin
      drive_reg <= 1'b0;
    end
  end

  // Clamp timer for the reset wire.
  always_ff @(posedge clock_i) begin
    if (srst_i || !(lo_run || hi_run) || ev_fs) begin
      clamp_cnt_reg <= 24'h000000;
    end else begin
      clamp_cnt_reg <= clamp_cnt_reg + 24'h000001;
    end
  end

  // Watchdog and start-up timer.
  always_ff @(posedge clock_i) begin
    if (srst_i || ev_rst || ev_fs || svc_ok || wd_wake || go != state_reg
        || (drive_reg && is_start)) begin
      wd_cnt_reg <= 24'h000000;
    end else if (wd_run_reg || is_start) begin
      wd_cnt_reg <= wd_cnt_reg + 24'h000001;
    end
  end

  // Period selection and off behaviour.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      per_reg <= wrs_period(4'h0, 2'h0, UNIT_C);
      off_sel_reg <= 1'b0;
      wd_run_reg <= 1'b1;
      cur_low_seen_reg <= 1'b0;
    end else begin
      if (svc_ok && !off_code) begin
        per_reg <= wrs_period(link.svc_period, link.svc_presc, UNIT_C);
      end else if (svc_ok && max_per) begin
        per_reg <= wrs_period(`WRS_PERIOD_MAX, `WRS_PRESC_MAX, UNIT_C);
      end
      if (ev_rst || ev_fs) begin
        off_sel_reg <= 1'b0;
      end else if (svc_ok) begin
        off_sel_reg <= off_code;
      end
      if (wd_stop) begin
        wd_run_reg <= 1'b0;
      end else if (ev_rst || ev_fs || svc_ok || wd_wake) begin
        wd_run_reg <= 1'b1;
      end
      if (ev_rst || svc_ok || wd_wake) begin
        cur_low_seen_reg <= 1'b0;
      end else if (state_reg == ST_STANDBY && off_sel_reg && in_s2[3]) begin
        cur_low_seen_reg <= 1'b1;
      end
    end
  end

  // Length select, enable bit, regulator and interrupt.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rlc_reg <= 1'b0;
      en_reg <= 1'b0;
      v1_en_reg <= 1'b1;
      wdr_irq_reg <= 1'b0;
    end else begin
      if (set_rlc || ev_fs || (svc_ok && link.svc_rlc)) begin
        rlc_reg <= 1'b1;
      end
      if (ev_rst || ev_fs || drive_reg) begin
        en_reg <= 1'b0;
      end else if (svc_ok && go == state_reg
                   && (state_reg == ST_NORMAL || state_reg == ST_FLASH)) begin
        en_reg <= link.svc_en;
      end
      v1_en_reg <= !(go == ST_SLEEP || go == ST_FAILSAFE);
      wdr_irq_reg <= wd_wake && wdr_irq_en_i;
    end
  end

  // Outputs.
  assign link.dev_rst_out = 1'b0;
  assign link.dev_rst_oe = drive_reg;
  assign link.rst_src = src_reg;
  assign link.en_level = en_reg;
  assign state_o = state_reg;
  assign v1_en_o = v1_en_reg;
  assign rlc_o = rlc_reg;
  assign wdr_irq_o = wdr_irq_reg;
endmodule

`default_nettype wire

// >>> include/wrs_consts.svh
`ifndef WRS_CONSTS_SVH
`define WRS_CONSTS_SVH

// Clock rate and documented or chosen times, in their own units.
`define WRS_CLK_MHZ 20
`define WRS_SHORT_RST_US 1000
`define WRS_LONG_RST_US 20000
`define WRS_STARTUP_US 256000
`define WRS_CLAMP_LOW_US 2000
`define WRS_CLAMP_HIGH_US 500
`define WRS_WD_UNIT_US 10

// Watchdog coding: ten period codes, four prescaler settings, one off code.
`define WRS_PERIOD_CODES 4'hA
`define WRS_PERIOD_MAX 4'h9
`define WRS_PRESC_MAX 2'h3
`define WRS_PERIOD_OFF 4'hF

// Operating mode codes; the other two of eight are illegal.
`define WRS_MODE_NORMAL 3'h5
`define WRS_MODE_STANDBY 3'h1
`define WRS_MODE_SLEEP 3'h2
`define WRS_MODE_FLASH_SVC 3'h7
`define WRS_MODE_FLASH_ENTER 3'h3
`define WRS_MODE_FLASH_EXIT 3'h6

// Reset source codes.
`define WRS_SRC_POR 4'h0
`define WRS_SRC_UV 4'h1
`define WRS_SRC_CURRENT 4'h2
`define WRS_SRC_EXT 4'h3
`define WRS_SRC_STARTUP 4'h4
`define WRS_SRC_WAKE 4'h5
`define WRS_SRC_FLASH_PREP 4'h6
`define WRS_SRC_FLASH_EXIT 4'h7
`define WRS_SRC_FS_WAKE 4'h8
`define WRS_SRC_WD 4'h9
`define WRS_SRC_ILL_MODE 4'hA
`define WRS_SRC_IRQ 4'hB

// Host register byte offsets and field positions.
`define WRS_REG_SERVICE 4'h0
`define WRS_REG_STATUS 4'h4
`define WRS_REG_CONTROL 4'h8
`define WRS_SVC_PERIOD_LSB 0
`define WRS_SVC_PRESC_LSB 4
`define WRS_SVC_MODE_LSB 6
`define WRS_SVC_EN_BIT 9
`define WRS_SVC_RLC_BIT 10
`define WRS_CTRL_FORCE_BIT 0

`endif

// >>> include/wrs_pkg.sv
package wrs_pkg;

  // Supervisor operating states.
  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_RESTART,
    ST_NORMAL,
    ST_STANDBY,
    ST_SLEEP,
    ST_FLASH,
    ST_FAILSAFE
  } wrs_state_t;

  // Accepts the six legal mode codes.
  function automatic logic wrs_mode_ok(input logic [2:0] m);
    return (m != 3'h0) && (m != 3'h4);
  endfunction

  // Period length in clock cycles from code, prescaler and unit.
  function automatic logic [23:0] wrs_period(input logic [3:0] c, input logic [1:0] p,
                                             input logic [23:0] unit);
    return unit << (c + {2'h0, p});
  endfunction

endpackage

// >>> include/wrs_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface wrs_link_if;
  logic svc_valid;
  logic [3:0] svc_period;
  logic [1:0] svc_presc;
  logic [2:0] svc_mode;
  logic svc_en;
  logic svc_rlc;
  logic dev_rst_out;
  logic dev_rst_oe;
  logic host_rst_out;
  logic host_rst_oe;
  logic rst_level;
  logic [3:0] rst_src;
  logic en_level;

  // Open-drain reset wire with pull-up: low while any driver enables a low.
  assign rst_level = !((dev_rst_oe && !dev_rst_out) || (host_rst_oe && !host_rst_out));

  modport dev(input svc_valid, svc_period, svc_presc, svc_mode, svc_en, svc_rlc, rst_level,
              output dev_rst_out, dev_rst_oe, rst_src, en_level);
  modport host(output svc_valid, svc_period, svc_presc, svc_mode, svc_en, svc_rlc,
               output host_rst_out, host_rst_oe, input rst_level, rst_src, en_level);
endinterface

`default_nettype wire

// >>> hw/wrs_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "wrs_consts.svh"

module wrs_host (
  input wire logic clock_i, // System clock.
  input wire logic srst_i, // Synchronous reset.
  wrs_link_if.host link, // Service strobes, reset wire and status.
  input wire logic [3:0] avs_address_i, // Byte address.
  input wire logic avs_read_i, // Read request.
  input wire logic avs_write_i, // Write request.
  input wire logic [31:0] avs_writedata_i, // Write data.
  output logic [31:0] avs_readdata_o, // Read data.
  output logic avs_waitrequest_o // Low for one cycle per accepted access.
);
  import wrs_pkg::*;

  logic wait_reg, svc_valid_reg, force_reg, pin_s1, pin_s2;
  logic [10:0] svc_word_reg;
  logic [31:0] rdata_reg, rd_mux;
  logic wr_acc;

  // Writes take effect at the edge that sees waitrequest low.
  assign wr_acc = avs_write_i && !wait_reg;

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    case (avs_address_i)
      `WRS_REG_SERVICE: rd_mux = {21'h000000, svc_word_reg};
      `WRS_REG_STATUS: rd_mux = {23'h000000, link.en_level, link.rst_src, 3'h0, pin_s2};
      `WRS_REG_CONTROL: rd_mux = {31'h00000000, force_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Waitrequest drops for one cycle after a request is seen.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if ((avs_read_i || avs_write_i) && wait_reg) begin
      wait_reg <= 1'b0;
      rdata_reg <= rd_mux;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Service word launches one strobe to the supervisor.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      svc_valid_reg <= 1'b0;
      svc_word_reg <= 11'h000;
      force_reg <= 1'b0;
    end else begin
      svc_valid_reg <= wr_acc && avs_address_i == `WRS_REG_SERVICE;
      if (wr_acc && avs_address_i == `WRS_REG_SERVICE) begin
        svc_word_reg <= avs_writedata_i[10:0];
      end
      if (wr_acc && avs_address_i == `WRS_REG_CONTROL) begin
        force_reg <= avs_writedata_i[`WRS_CTRL_FORCE_BIT];
      end
    end
  end

  // The reset wire is a pin and is synchronised.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      pin_s1 <= link.rst_level;
      pin_s2 <= pin_s1;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign link.svc_valid = svc_valid_reg;
  assign link.svc_period = svc_word_reg[`WRS_SVC_PRESC_LSB-1:`WRS_SVC_PERIOD_LSB];
  assign link.svc_presc = svc_word_reg[`WRS_SVC_MODE_LSB-1:`WRS_SVC_PRESC_LSB];
  assign link.svc_mode = svc_word_reg[`WRS_SVC_EN_BIT-1:`WRS_SVC_MODE_LSB];
  assign link.svc_en = svc_word_reg[`WRS_SVC_EN_BIT];
  assign link.svc_rlc = svc_word_reg[`WRS_SVC_RLC_BIT];
  assign link.host_rst_out = 1'b0;
  assign link.host_rst_oe = force_reg;
endmodule

`default_nettype wire

// >>> bench/wrs_props.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the link between the supervisor and its host.
module wrs_props #(
  parameter int unsigned SHORT_RST_CYC = 8,
  parameter int unsigned LONG_RST_CYC = 16,
  parameter int unsigned CLAMP_LOW_CYC = 60
) (
  input wire logic clock_i, // System clock.
  input wire logic srst_i, // Synchronous reset.
  input wire logic svc_valid, // Service strobe.
  input wire logic [3:0] svc_period, // Period code.
  input wire logic [2:0] svc_mode, // Mode code.
  input wire logic svc_en, // Enable bit written.
  input wire logic dev_rst_oe, // Device pulls the wire low.
  input wire logic host_rst_oe, // Host pulls the wire low.
  input wire logic rst_level, // Wire level.
  input wire logic [3:0] rst_src, // Reset source.
  input wire logic en_level // Safe enable output.
);
  logic [31:0] hold_cnt;
  logic [31:0] low_cnt;
  logic en_req;
  logic mode_bad;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Strobe qualifiers for the code checks.
  assign en_req = svc_valid && svc_en;
  assign mode_bad = (svc_mode == 3'h0) || (svc_mode == 3'h4);
  // Length of the present reset pulse.
  always_ff @(posedge clock_i) begin
    hold_cnt <= (srst_i || !dev_rst_oe) ? 32'h0 : hold_cnt + 32'h1;
  end
  // Time the wire stays low once the device has let go.
  always_ff @(posedge clock_i) begin
    low_cnt <= (srst_i || dev_rst_oe || rst_level) ? 32'h0 : low_cnt + 32'h1;
  end
  a_pulse_length: assert property (
    $fell(dev_rst_oe) |-> hold_cnt >= SHORT_RST_CYC && hold_cnt <= LONG_RST_CYC + 8)
    else $error("reset pulse length out of range");
  a_src_on_reset: assert property ($changed(rst_src) |-> dev_rst_oe)
    else $error("reset source changed without a reset");
  a_illegal_mode: assert property (
    svc_valid && !dev_rst_oe && svc_period <= 4'h9 && mode_bad |=> dev_rst_oe && rst_src == 4'hA)
    else $error("illegal mode code not punished");
  a_bad_period: assert property (
    svc_valid && !dev_rst_oe && svc_period inside {[4'hA:4'hE]} && !mode_bad
    |=> dev_rst_oe && rst_src == 4'h9)
    else $error("illegal period code not punished");
  a_ext_reset: assert property (
    $rose(host_rst_oe) && !dev_rst_oe |-> ##[1:5] (dev_rst_oe && rst_src == 4'h3))
    else $error("external reset not taken up");
  a_en_cleared: assert property (dev_rst_oe [*2] |-> !en_level)
    else $error("enable high during reset");
  a_en_by_host: assert property ($rose(en_level) |-> $past(en_req) || $past(en_req, 2))
    else $error("enable rose without a write");
  a_clamp_low: assert property (low_cnt <= CLAMP_LOW_CYC + 5)
    else $error("clamped low wire not caught");
endmodule
`default_nettype wire

// >>> bench/wrs_bench.sv
`timescale 1ns/10ps
`default_nettype none
// Joins both ends and checks the reset behaviour at the link.
module wrs_bench;
  import wrs_pkg::*;
  typedef struct {logic [1:0] k; logic [31:0] w; logic [3:0] src;} wrs_row_t;
  localparam int SHORT = 8;
  localparam int LONG = 16;
  localparam int CLOW = 60;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [2:0] below = 3'h0;
  logic [1:0] uv_sel = 2'h0;
  logic irq_late = 1'b0;
  logic zero = 1'b0;
  logic cur_lo = 1'b0;
  logic cur_hi = 1'b0;
  logic reset_length_select;
  logic v1_en;
  wrs_state_t st;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic [31:0] s;
  wrs_row_t rows[8];
  wrs_link_if lk();
  wrs_device #(.SHORT_RST_CYC(SHORT), .LONG_RST_CYC(LONG), .STARTUP_CYC(200),
    .CLAMP_LOW_CYC(CLOW), .CLAMP_HIGH_CYC(20), .WD_UNIT_CYC(4)) wrs_device_i (
    .clock_i(clock_i), .srst_i(srst_i), .link(lk.dev), .v1_below_i(below),
    .uv_sel_i(uv_sel), .cur_low_i(cur_lo), .cur_high_i(cur_hi), .wake_i(zero),
    .irq_late_i(irq_late), .wdr_irq_en_i(zero), .state_o(st), .v1_en_o(v1_en), .rlc_o(reset_length_select),
    .wdr_irq_o());
  wrs_host wrs_host_i (.clock_i(clock_i), .srst_i(srst_i), .link(lk.host),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));
  wrs_props #(.SHORT_RST_CYC(SHORT), .LONG_RST_CYC(LONG), .CLAMP_LOW_CYC(CLOW)) wrs_props_i (
    .clock_i(clock_i), .srst_i(srst_i), .svc_valid(lk.svc_valid), .svc_period(lk.svc_period),
    .svc_mode(lk.svc_mode), .svc_en(lk.svc_en), .dev_rst_oe(lk.dev_rst_oe),
    .host_rst_oe(lk.host_rst_oe), .rst_level(lk.rst_level), .rst_src(lk.rst_src),
    .en_level(lk.en_level));
  // Clock and a cycle ceiling that cuts a hang short.
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clock_i); while (wreq !== 1'b0);
    s = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Service word with prescaler zero and length select clear.
  function automatic logic [31:0] sv(input logic [3:0] p, input logic [2:0] m, input logic e);
    return {21'h0, 1'b0, e, m, 2'h0, p};
  endfunction
  // Waits for the device to let go of, or to pull, the wire.
  task automatic free();
    while (lk.dev_rst_oe !== 1'b0) @(posedge clock_i);
  endtask
  task automatic hit();
    while (lk.dev_rst_oe !== 1'b1) @(posedge clock_i);
  endtask
  // Counts the cycles of the next reset pulse.
  task automatic span();
    n = 0;
    hit();
    while (lk.dev_rst_oe === 1'b1) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  // Reads the status after release: source code and a cleared enable.
  task automatic src_is(input logic [3:0] e);
    free();
    bus(1'b0, 4'h4, 32'h0);
    chk(s[7:4], e);
    chk(s[8], 1'b0);
  endtask
  // Goes from start-up through Normal into Standby, then serves once more at once.
  task automatic stby(input logic [3:0] p);
    bus(1'b1, 4'h0, sv(4'h2, 3'h5, 1'b0));
    repeat (9) @(posedge clock_i);
    bus(1'b1, 4'h0, sv(4'h2, 3'h1, 1'b0));
    bus(1'b1, 4'h0, sv(p, 3'h1, 1'b0));
    repeat (2) @(posedge clock_i);
    chk(st, ST_STANDBY);
    chk(lk.dev_rst_oe, 1'b0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Rows: kind 0 service word, 1 late interrupt, 2 host force, 3 undervoltage.
  initial begin
    rows = '{'{2'h0, sv(4'h2, 3'h0, 1'b0), 4'hA}, '{2'h0, sv(4'h2, 3'h4, 1'b0), 4'hA},
      '{2'h0, sv(4'hA, 3'h5, 1'b0), 4'h9}, '{2'h0, sv(4'hE, 3'h5, 1'b0), 4'h9},
      '{2'h1, 32'h0, 4'hB}, '{2'h2, 32'h0, 4'h3}, '{2'h3, 32'h01, 4'h1}, '{2'h3, 32'h34, 4'h1}};
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    span();
    chk(n >= SHORT && n <= SHORT + 3, 1'b1);
    chk(lk.rst_src, 4'h0);
    foreach (rows[i]) begin
      free();
      case (rows[i].k)
        2'h0: bus(1'b1, 4'h0, rows[i].w);
        2'h2: begin
          bus(1'b1, 4'h8, 32'h1);
          bus(1'b1, 4'h8, 32'h0);
        end
        default: begin
          uv_sel <= rows[i].w[5:4];
          below <= rows[i].w[2:0];
          irq_late <= (rows[i].k == 2'h1);
          repeat (4) @(posedge clock_i);
          below <= 3'h0;
          irq_late <= 1'b0;
        end
      endcase
      hit();
      src_is(rows[i].src);
    end
    // Standby time-out after an early period change, then off under current watch.
    stby(4'h3);
    hit();
    src_is(4'h9);
    stby(4'hF);
    cur_lo <= 1'b1;
    repeat (40) @(posedge clock_i);
    chk(st, ST_STANDBY);
    cur_lo <= 1'b0;
    cur_hi <= 1'b1;
    hit();
    cur_hi <= 1'b0;
    src_is(4'h2);
    // Window service, a period change inside the window, then an early one.
    bus(1'b1, 4'h0, sv(4'h2, 3'h5, 1'b1));
    repeat (9) @(posedge clock_i);
    bus(1'b1, 4'h0, sv(4'h3, 3'h5, 1'b1));
    repeat (17) @(posedge clock_i);
    bus(1'b1, 4'h0, sv(4'h3, 3'h5, 1'b1));
    repeat (3) @(posedge clock_i);
    chk(lk.dev_rst_oe, 1'b0);
    chk(lk.en_level, 1'b1);
    chk(st, ST_NORMAL);
    @(posedge clock_i);
    bus(1'b1, 4'h0, sv(4'h3, 3'h5, 1'b1));
    src_is(4'h9);
    chk(st, ST_STARTUP);
    bus(1'b1, 4'h0, sv(4'h2, 3'h5, 1'b0));
    hit();
    src_is(4'h9);
    // Two unserved start-ups in a row end in fail-safe.
    span();
    chk(n >= LONG, 1'b1);
    chk(reset_length_select, 1'b1);
    src_is(4'h4);
    hit();
    repeat (2) @(posedge clock_i);
    chk(st, ST_FAILSAFE);
    chk(v1_en, 1'b0);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    chk(reset_length_select, 1'b0);
    // The host holds the wire low past the clamp limit.
    free();
    bus(1'b1, 4'h8, 32'h1);
    repeat (120) @(posedge clock_i);
    chk(st, ST_FAILSAFE);
    bus(1'b1, 4'h8, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
